// File: rtl/digital_io_group.sv
// Two input groups with rise latches and two output groups behind a Wishbone slave
//
// Summary of operation
// - Each input group has a level register and a rise latch register, 16 bits.
// - Level register bits follow their input points, except in the cycle the program reads them.
// - Latch bit sets on first rising edge of its input and stays set until the program reads it.
// - Newly set latch bit raises process interrupt only when that group is armed.
// - Each output group holds a 16-bit program-written register driving its points.
// - Input diagnostic forces input data to all zeros or all ones.
// - Output diagnostic disables output line drive.
// - Output read-back returns the last value written to the output register.
// - Two input groups and two output groups of 16 points each.
// - Each group addressable, with a ready and a sync handshake line.
// - Sync handshake use is enabled per group by program setting.
`include "dio_regs.svh"
`default_nettype none
module digital_io_group #(
    parameter int GW = 16
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Wishbone slave
    input  wire logic            cyc_i,
    input  wire logic            stb_i,
    input  wire logic            we_i,
    input  wire logic [5:0]      adr_i,
    input  wire logic [3:0]      sel_i,
    input  wire logic [31:0]     dat_i,
    output logic      [31:0]     dat_o,
    output logic                 ack_o,
    // Input points and handshake
    input  wire logic [2*GW-1:0] in_pts_i,
    input  wire logic [3:0]      sync_i,
    output logic      [3:0]      ready_o,
    // Output points
    output logic      [2*GW-1:0] out_pts_o,
    output logic      [2*GW-1:0] out_oe_o,
    // Process interrupt, one per input group
    output logic      [1:0]      proc_irq_o
);

    // ****************************************
    // State
    // ****************************************
    logic [GW-1:0]                 level_q [2];
    logic [GW-1:0]                 latch_q [2];
    logic [GW-1:0]                 prev_q  [2];
    logic [GW-1:0]                 drive_q [2];
    logic [`DIO_CTRL_WIDTH-1:0]    ctrl_q;
    logic [3:0]                    sync_seen_q;
    dio_pkg::bus_state_t           bus_q;
    logic [GW-1:0]                 eff_in  [2];
    logic                          req;
    logic                          rd_level0, rd_level1, rd_latch0, rd_latch1;

    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : lane_merge

    assign req       = cyc_i && stb_i && (bus_q == dio_pkg::BUS_IDLE);
    assign rd_level0 = req && !we_i && (adr_i == `DIO_IN_LEVEL0_OFF);
    assign rd_level1 = req && !we_i && (adr_i == `DIO_IN_LEVEL1_OFF);
    assign rd_latch0 = req && !we_i && (adr_i == `DIO_IN_LATCH0_OFF);
    assign rd_latch1 = req && !we_i && (adr_i == `DIO_IN_LATCH1_OFF);

    // ****************************************
    // Input selection and diagnostic forcing
    // ****************************************
    always_comb begin
        eff_in[0] = ctrl_q[`DIO_CTRL_FRCEN0_BIT]
                  ? {GW{ctrl_q[`DIO_CTRL_FRCVAL0_BIT]}} : in_pts_i[GW-1:0];
        eff_in[1] = ctrl_q[`DIO_CTRL_FRCEN1_BIT]
                  ? {GW{ctrl_q[`DIO_CTRL_FRCVAL1_BIT]}} : in_pts_i[2*GW-1:GW];
    end

    // ****************************************
    // Level tracking and rise latches
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int g = 0; g < 2; g++) begin
                level_q[g] <= '0;
                prev_q[g]  <= '0;
            end
        end else begin
            for (int g = 0; g < 2; g++) begin
                prev_q[g]  <= eff_in[g];
                // Tracking stops in the cycle of a read so the bus sees a stable word
                if (!((g == 0) ? rd_level0 : rd_level1)) begin
                    level_q[g] <= eff_in[g];
                end
            end
        end
    end

    // A rise in the same cycle as the clearing read is kept: set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q[0] <= '0;
            latch_q[1] <= '0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                latch_q[g] <= (((g == 0) ? rd_latch0 : rd_latch1) ? '0 : latch_q[g])
                            | (eff_in[g] & ~prev_q[g]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            proc_irq_o <= 2'h0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                // One-cycle pulse when a latch bit newly goes high
                proc_irq_o[g] <= ctrl_q[`DIO_CTRL_ARM0_BIT + g]
                              && |(eff_in[g] & ~prev_q[g] & ~latch_q[g]);
            end
        end
    end

    // ****************************************
    // Handshake: ready and sync per group
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_seen_q <= 4'h0;
            ready_o     <= 4'h0;
        end else begin
            for (int g = 0; g < 4; g++) begin
                // With sync enabled a group is ready only after the device strobes sync
                if (ctrl_q[`DIO_CTRL_SYNC_LSB + g]) begin
                    if (sync_i[g]) begin
                        sync_seen_q[g] <= 1'b1;
                    end else if (req && !we_i && adr_i == `DIO_STATUS_OFF) begin
                        // A strobe meeting the clearing status read is kept: set wins
                        sync_seen_q[g] <= 1'b0;
                    end
                end else begin
                    sync_seen_q[g] <= 1'b0;
                end
                ready_o[g] <= !ctrl_q[`DIO_CTRL_SYNC_LSB + g] || sync_seen_q[g] || sync_i[g];
            end
        end
    end

    // ****************************************
    // Output registers and drivers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_q[0] <= `DIO_OUT_RESET;
            drive_q[1] <= `DIO_OUT_RESET;
            ctrl_q     <= `DIO_CTRL_RESET;
        end else if (req && we_i) begin
            case (adr_i)
                `DIO_OUT_DRIVE0_OFF: drive_q[0] <= lane_merge(drive_q[0], dat_i, sel_i);
                `DIO_OUT_DRIVE1_OFF: drive_q[1] <= lane_merge(drive_q[1], dat_i, sel_i);
                `DIO_CTRL_OFF: begin
                    ctrl_q[7:0] <= sel_i[0] ? dat_i[7:0] : ctrl_q[7:0];
                    ctrl_q[11:8] <= sel_i[1] ? dat_i[11:8] : ctrl_q[11:8];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_pts_o <= '0;
            out_oe_o  <= '0;
        end else begin
            out_pts_o <= {drive_q[1], drive_q[0]};
            out_oe_o  <= {{GW{!ctrl_q[`DIO_CTRL_ODIS1_BIT]}}, {GW{!ctrl_q[`DIO_CTRL_ODIS0_BIT]}}};
        end
    end

    // ****************************************
    // Bus answer: one registered ack the cycle after the request, dropped the cycle after
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= dio_pkg::BUS_IDLE;
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            case (bus_q)
                dio_pkg::BUS_IDLE: begin
                    ack_o <= req;
                    if (req) begin
                        bus_q <= dio_pkg::BUS_ACK;
                        dat_o <= 32'h0000_0000;
                        if (!we_i) begin
                            case (adr_i)
                                `DIO_IN_LEVEL0_OFF:  dat_o[15:0] <= level_q[0];
                                `DIO_IN_LATCH0_OFF:  dat_o[15:0] <= latch_q[0];
                                `DIO_IN_LEVEL1_OFF:  dat_o[15:0] <= level_q[1];
                                `DIO_IN_LATCH1_OFF:  dat_o[15:0] <= latch_q[1];
                                `DIO_OUT_DRIVE0_OFF: dat_o[15:0] <= drive_q[0];
                                `DIO_OUT_DRIVE1_OFF: dat_o[15:0] <= drive_q[1];
                                `DIO_CTRL_OFF:       dat_o[11:0] <= ctrl_q;
                                `DIO_STATUS_OFF:     dat_o[5:0]  <= {sync_seen_q, proc_irq_o};
                                default:             dat_o       <= 32'h0000_0000;
                            endcase
                        end
                    end
                end
                dio_pkg::BUS_ACK: begin
                    ack_o <= 1'b0;
                    bus_q <= dio_pkg::BUS_IDLE;
                end
                default: begin
                    ack_o <= 1'b0;
                    bus_q <= dio_pkg::BUS_IDLE;
                end
            endcase
        end
    end

endmodule : digital_io_group
`default_nettype wire

// File: pkg/dio_regs.svh
// Register offsets, field positions and reset values of the digital I/O groups
`ifndef DIO_REGS_SVH
`define DIO_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DIO_IN_LEVEL0_OFF   6'h00
`define DIO_IN_LATCH0_OFF   6'h04
`define DIO_IN_LEVEL1_OFF   6'h08
`define DIO_IN_LATCH1_OFF   6'h0c
`define DIO_OUT_DRIVE0_OFF  6'h10
`define DIO_OUT_DRIVE1_OFF  6'h14
`define DIO_CTRL_OFF        6'h18
`define DIO_STATUS_OFF      6'h1c

// ****************************************
// Control register fields (per group g: in 0..1, out 0..1)
// ****************************************
`define DIO_CTRL_ARM0_BIT    0
`define DIO_CTRL_ARM1_BIT    1
`define DIO_CTRL_FRCEN0_BIT  2
`define DIO_CTRL_FRCEN1_BIT  3
`define DIO_CTRL_FRCVAL0_BIT 4
`define DIO_CTRL_FRCVAL1_BIT 5
`define DIO_CTRL_ODIS0_BIT   6
`define DIO_CTRL_ODIS1_BIT   7
`define DIO_CTRL_SYNC_LSB    8
`define DIO_CTRL_WIDTH       12

// ****************************************
// Status register fields
// ****************************************
`define DIO_STAT_IRQ_LSB     0
`define DIO_STAT_SYNC_LSB    2

// ****************************************
// Reset values
// ****************************************
`define DIO_CTRL_RESET       12'h000
`define DIO_OUT_RESET        16'h0000

`endif

// File: pkg/dio_pkg.sv
// Types shared by the digital I/O group block
`default_nettype none
package dio_pkg;
    typedef logic [15:0] group_word_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;
endpackage : dio_pkg
`default_nettype wire

// File: tb/dio_field_model.sv
// Field side model: sensor contacts, sync lines and output loads
`default_nettype none
module dio_field_model (
    // Clock and commanded field state
    input  wire logic        clk_i,
    input  wire logic [31:0] level_i,
    input  wire logic [3:0]  sync_req_i,
    // Block's output points
    input  wire logic [31:0] out_pts_i,
    input  wire logic [31:0] out_oe_i,
    // Seen by the block and by the loads
    output logic      [31:0] in_pts_o,
    output logic      [3:0]  sync_o,
    output logic      [31:0] load_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contacts change just after an edge, never on it
    always_ff @(posedge clk_i) begin
        in_pts_o <= level_i;
        sync_o   <= sync_req_i;
    end
    // Loads are pulled low when the point is not driven
    assign load_o = out_pts_i & out_oe_i;
endmodule : dio_field_model
`default_nettype wire

// File: tb/digital_io_group_asserts.sv
// Port checker for the digital I/O group block
`default_nettype none
module digital_io_group_asserts #(
    parameter int GW = 16
) (
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            cyc_i,
    input wire logic            stb_i,
    input wire logic            we_i,
    input wire logic [5:0]      adr_i,
    input wire logic [3:0]      sel_i,
    input wire logic [31:0]     dat_i,
    input wire logic [31:0]     dat_o,
    input wire logic            ack_o,
    input wire logic [2*GW-1:0] in_pts_i,
    input wire logic [2*GW-1:0] out_oe_o,
    input wire logic [2*GW-1:0] out_pts_o,
    input wire logic [1:0]      proc_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [GW-1:0] prev_q;
    logic [3:0]    hist_q;
    logic          rise;
    assign rise = |(in_pts_i[GW-1:0] & ~prev_q);
    // Recent rises on group 0; an interrupt must follow one of them
    always_ff @(posedge clk_i) begin
        prev_q <= in_pts_i[GW-1:0];
        hist_q <= {hist_q[2:0], rise};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && proc_irq_o == 2'h0
        && out_pts_o == '0) else $error("outputs active after reset");
    a_unmapped_read: assert property (ack_o && !we_i && adr_i >= 6'h20 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_drive_follow: assert property (ack_o && we_i && adr_i == 6'h10 && sel_i[1:0] == 2'h3
        |=> out_pts_o[GW-1:0] == $past(dat_i[GW-1:0])) else $error("output points do not follow");
    a_oe_follow: assert property (ack_o && we_i && adr_i == 6'h18 && sel_i[0]
        |=> out_oe_o[GW-1:0] == {GW{!$past(dat_i[6])}}) else $error("output enable wrong");
    a_irq_cause: assert property (proc_irq_o[0] |-> rise || |hist_q) else $error("irq without rise");
endmodule : digital_io_group_asserts
bind digital_io_group digital_io_group_asserts #(.GW(GW)) digital_io_group_asserts_inst (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .in_pts_i, .out_oe_o, .out_pts_o, .proc_irq_o);
`default_nettype wire

// File: tb/tb_digital_io_group.sv
// Testbench for the digital I/O group block
`default_nettype none
module tb_digital_io_group;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [5:0]  adr_i;
    logic [3:0]  sel_i, sync_i, sync_req, ready_o;
    logic [1:0]  proc_irq_o;
    logic [31:0] dat_i, dat_o, in_pts_i, out_pts_o, out_oe_o, lvl, load, q;
    int          err_count, checks;
    digital_io_group digital_io_group_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .in_pts_i, .sync_i, .ready_o, .out_pts_o, .out_oe_o, .proc_irq_o);
    dio_field_model dio_field_model_inst (.clk_i, .level_i(lvl), .sync_req_i(sync_req),
        .out_pts_i(out_pts_o), .out_oe_i(out_oe_o), .in_pts_o(in_pts_i), .sync_o(sync_i), .load_o(load));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One classic cycle; waits for ack however long it takes
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 6'h00, 4'h3, 32'h0};
        {lvl, sync_req} = 36'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(6'h18, 32'h0);
        wb(1'b1, 6'h10, 32'ha5c3);
        wb(1'b1, 6'h14, 32'h3c5a);
        rd(6'h10, 32'ha5c3);
        rd(6'h14, 32'h3c5a);
        chk(load, 32'h3c5a_a5c3);
        wb(1'b1, 6'h18, 32'h40);
        repeat (2) @(posedge clk_i);
        chk(load, 32'h3c5a_0000);
        $display("output test done");
        lvl <= 32'h1234_8001;
        repeat (3) @(posedge clk_i);
        rd(6'h00, 32'h8001);
        rd(6'h08, 32'h1234);
        wb(1'b1, 6'h18, 32'h14);
        rd(6'h00, 32'hffff);
        wb(1'b1, 6'h18, 32'h04);
        rd(6'h00, 32'h0);
        wb(1'b1, 6'h18, 32'h0);
        $display("input test done");
        // Clear latches left by the steps above
        lvl <= 32'h0;
        repeat (3) @(posedge clk_i);
        wb(1'b0, 6'h04, 32'h0);
        wb(1'b0, 6'h0c, 32'h0);
        lvl <= 32'h0001_0008;
        repeat (3) @(posedge clk_i);
        lvl <= 32'h0;
        repeat (3) @(posedge clk_i);
        rd(6'h04, 32'h0008);
        rd(6'h0c, 32'h0001);
        rd(6'h04, 32'h0);
        wb(1'b1, 6'h18, 32'h1);
        lvl <= 32'h0020_0020;
        q = 32'h0;
        repeat (8) begin
            @(posedge clk_i);
            q = q | {30'h0, proc_irq_o};
        end
        chk(q, 32'h1);
        $display("latch test done");
        wb(1'b1, 6'h24, 32'hffff);
        rd(6'h24, 32'h0);
        wb(1'b1, 6'h18, 32'h100);
        repeat (2) @(posedge clk_i);
        chk({28'h0, ready_o}, 32'he);
        sync_req <= 4'h1;
        repeat (4) @(posedge clk_i);
        chk({28'h0, ready_o}, 32'hf);
        rd(6'h1c, 32'h4);
        sync_req <= 4'h0;
        repeat (3) @(posedge clk_i);
        rd(6'h1c, 32'h4);
        rd(6'h1c, 32'h0);
        chk({28'h0, ready_o}, 32'he);
        $display("handshake test done");
        // Arm, then reset in mid-run: arming and output drive must come back cleared
        wb(1'b1, 6'h18, 32'h1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(6'h18, 32'h0);
        rd(6'h10, 32'h0);
        chk(load, 32'h0);
        $display("reset test done");
        summarize();
    end
endmodule : tb_digital_io_group
`default_nettype wire
